// ---- verilog/pnp_parallel_port.sv ----
`timescale 1ns/1ns
`default_nettype none
module pnp_parallel_port
	import pnp_pkg::*;
#(
	parameter int FLASH_AW = 10,
	parameter int EEPROM_AW = 9,
	parameter int FLASH_PAGE_AW = 6,
	parameter int EEPROM_PAGE_AW = 2,
	parameter int WRITE_CYCLES = pnp_pkg::WRITE_CYC,
	parameter int ERASE_CYCLES = pnp_pkg::ERASE_CYC,
	// Identity values are arbitrary
	parameter logic [7:0] SIG_BYTE0 = 8'h5a,
	parameter logic [7:0] SIG_BYTE1 = 8'h3c,
	parameter logic [7:0] SIG_BYTE2 = 8'h0f,
	parameter logic [7:0] CALIB_BYTE = 8'h80
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic loadStrobe,
	input wire logic actionSelectHi,
	input wire logic actionSelectLo,
	input wire logic byteSelectOne,
	input wire logic byteSelectTwo,
	input wire logic pageLatchStrobe,
	input wire logic writeN,
	input wire logic outputEnableN,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOe,
	output logic readyBusy,
	output logic pageLatchReady
);
	import pnp_pkg::*;

	localparam int CW = $clog2(ERASE_CYCLES + 1);

	if (FLASH_PAGE_AW >= FLASH_AW || EEPROM_PAGE_AW >= EEPROM_AW
		|| EEPROM_AW > FLASH_AW || FLASH_AW > 24 || FLASH_PAGE_AW > 8
		|| EEPROM_PAGE_AW > 8 || ERASE_CYCLES <= (1 << FLASH_AW)
		|| WRITE_CYCLES <= (1 << FLASH_PAGE_AW) || WRITE_CYCLES > ERASE_CYCLES)
	begin : gParamCheck
		$error("memory geometry or busy counts not supported");
	end

	// ------------------------------------------------------------
	// Loaded state
	// ------------------------------------------------------------
	logic [7:0] cmd;
	logic [7:0] addrLo;
	logic [7:0] addrHi;
	logic [7:0] addrExt;
	logic [7:0] dataLo;
	logic [7:0] dataHi;
	logic [7:0] fuseLow;
	logic [7:0] fuseHigh;
	logic [7:0] fuseExt;
	logic [7:0] lockBits;
	logic prevLoad;
	logic prevPage;
	logic prevWriteN;
	logic [CW-1:0] busyCnt;
	logic [CW-1:0] busyLen;
	logic [FLASH_AW:0] walkIdx;
	logic [23:0] opAddr;
	pnp_op_type activeOp;
	logic [(1<<FLASH_PAGE_AW)-1:0] flashValid;
	logic [(1<<EEPROM_PAGE_AW)-1:0] eepromValid;

	logic [15:0] flashMem [1<<FLASH_AW];
	logic [7:0] eepromMem [1<<EEPROM_AW];
	logic [15:0] flashPage [1<<FLASH_PAGE_AW];
	logic [7:0] eepromPage [1<<EEPROM_PAGE_AW];

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire pnp_action_type action =
		pnp_action_type'({actionSelectHi, actionSelectLo});
	wire [1:0] byteSel = {byteSelectTwo, byteSelectOne};
	wire loadRise = loadStrobe && !prevLoad;
	wire pageRise = pageLatchStrobe && !prevPage;
	wire writeFall = prevWriteN && !writeN;
	wire busy = (busyCnt != '0);
	wire [23:0] fullAddr = {addrExt, addrHi, addrLo};
	wire cmdLoad = clkEn && loadRise && action == ACT_CMD;
	wire pageSel = (byteSel == SEL_LOW);
	wire pnp_op_type reqOp =
		(cmd == CMD_ERASE) ? OP_ERASE :
		(cmd == CMD_WR_FUSE) ? OP_FUSE :
		(cmd == CMD_WR_LOCK) ? OP_LOCK :
		(cmd == CMD_WR_FLASH && pageSel) ? OP_FLASH :
		(cmd == CMD_WR_EEPROM && pageSel) ? OP_EEPROM : OP_IDLE;
	// Busy pulses fall through, so a second write never starts
	wire startOp = clkEn && writeFall && !busy && reqOp != OP_IDLE;
	wire isReadCmd = (cmd == CMD_RD_FLASH) || (cmd == CMD_RD_EEPROM)
		|| (cmd == CMD_RD_FUSE) || (cmd == CMD_RD_SIG);
	wire driveWant = !outputEnableN && isReadCmd;

	// Boot bits held when both basic bits read programmed
	wire [7:0] lockKeep = (lockBits[1:0] == 2'b00)
		? LOCK_BOOT_MASK : 8'h00;
	// Only ever clears bits; erase alone sets them back
	wire [7:0] lockNext = lockBits & (dataLo | lockKeep);

	// ------------------------------------------------------------
	// Page latch path
	// ------------------------------------------------------------
	pnp_latch_type latchIn;
	pnp_latch_type latchOut;
	logic latchOutValid;
	assign latchIn = '{eeprom: (cmd == CMD_WR_EEPROM), index: addrLo,
		word: {dataHi, dataLo}};
	// Entries wait while a page is being committed
	wire drainReady = !busy;
	wire drainFire = clkEn && latchOutValid && drainReady;

	pnp_skid_buffer #(.WIDTH($bits(pnp_latch_type)), .DEPTH(2)) latchBuf
	(
		.clk(clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.inValid(pageRise),
		.inData(latchIn),
		.inReady(pageLatchReady),
		.outValid(latchOutValid),
		.outData(latchOut),
		.outReady(drainReady)
	);

	// ------------------------------------------------------------
	// Commit walk
	// ------------------------------------------------------------
	wire walkOn = busy && !walkIdx[FLASH_AW];
	wire isErase = (activeOp == OP_ERASE);
	wire eraseDone = isErase && busyCnt == CW'(1);
	wire [FLASH_PAGE_AW-1:0] fWalk = walkIdx[FLASH_PAGE_AW-1:0];
	wire [EEPROM_PAGE_AW-1:0] eWalk = walkIdx[EEPROM_PAGE_AW-1:0];
	wire inFlashPage = (walkIdx[FLASH_AW:FLASH_PAGE_AW] == '0);
	wire inEepromPage = (walkIdx[FLASH_AW:EEPROM_PAGE_AW] == '0);
	wire flashWe = clkEn && walkOn && (isErase
		|| (activeOp == OP_FLASH && inFlashPage && flashValid[fWalk]));
	wire eepromWe = clkEn && walkOn && (isErase
		|| (activeOp == OP_EEPROM && inEepromPage && eepromValid[eWalk]));
	wire [FLASH_AW-1:0] flashWAddr = isErase ? walkIdx[FLASH_AW-1:0]
		: {opAddr[FLASH_AW-1:FLASH_PAGE_AW], fWalk};
	wire [EEPROM_AW-1:0] eepromWAddr = isErase ? walkIdx[EEPROM_AW-1:0]
		: {opAddr[EEPROM_AW-1:EEPROM_PAGE_AW], eWalk};

	always_ff @(posedge clk)
	begin
		if (flashWe)
			flashMem[flashWAddr] <= isErase ? ERASED_WORD : flashPage[fWalk];
		if (eepromWe)
			eepromMem[eepromWAddr] <= isErase ? ERASED_BYTE : eepromPage[eWalk];
	end

	always_ff @(posedge clk)
	begin
		if (drainFire && !latchOut.eeprom)
			flashPage[latchOut.index[FLASH_PAGE_AW-1:0]] <= latchOut.word;
		if (drainFire && latchOut.eeprom)
			eepromPage[latchOut.index[EEPROM_PAGE_AW-1:0]] <= latchOut.word[7:0];
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	wire [15:0] flashRdWord = flashMem[fullAddr[FLASH_AW-1:0]];
	wire [7:0] eepromRdByte = eepromMem[fullAddr[EEPROM_AW-1:0]];
	wire [7:0] sigByte = (addrLo == 8'h00) ? SIG_BYTE0 :
		(addrLo == 8'h01) ? SIG_BYTE1 :
		(addrLo == SIG_LAST) ? SIG_BYTE2 : SIG_NONE;
	wire [7:0] fuseRdByte = (byteSel == SEL_LOW) ? fuseLow :
		(byteSel == SEL_TOP) ? fuseHigh :
		(byteSel == SEL_EXT) ? fuseExt : lockBits;
	wire [7:0] readData =
		(cmd == CMD_RD_FLASH) ? (byteSelectOne ? flashRdWord[15:8]
			: flashRdWord[7:0]) :
		(cmd == CMD_RD_EEPROM) ? eepromRdByte :
		(cmd == CMD_RD_FUSE) ? fuseRdByte :
		(byteSelectOne ? CALIB_BYTE : sigByte);
	assign readyBusy = !busy;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			prevLoad <= 1'b0;
			prevPage <= 1'b0;
			prevWriteN <= 1'b1;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
		end
		else if (clkEn)
		begin
			prevLoad <= loadStrobe;
			prevPage <= pageLatchStrobe;
			prevWriteN <= writeN;
			dataOut <= readData;
			dataOe <= driveWant;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cmd <= CMD_NOP;
			addrLo <= 8'h00;
			addrHi <= 8'h00;
			addrExt <= 8'h00;
			dataLo <= 8'h00;
			dataHi <= 8'h00;
		end
		else if (clkEn && loadRise)
		begin
			// Values persist until the same selector reloads them
			unique case (action)
				ACT_CMD: cmd <= dataIn;
				ACT_ADDR:
				begin
					if (byteSel == SEL_LOW)
						addrLo <= dataIn;
					else if (byteSel == SEL_HIGH)
						addrHi <= dataIn;
					else if (byteSel == SEL_EXT)
						addrExt <= dataIn;
				end
				ACT_DATA:
				begin
					if (byteSelectOne)
						dataHi <= dataIn;
					else
						dataLo <= dataIn;
				end
				ACT_IDLE: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			busyCnt <= '0;
			busyLen <= '0;
			walkIdx <= '0;
			opAddr <= 24'h000000;
			activeOp <= OP_IDLE;
		end
		else if (clkEn)
		begin
			if (startOp)
			begin
				busyCnt <= (reqOp == OP_ERASE) ? CW'(ERASE_CYCLES)
					: CW'(WRITE_CYCLES);
				busyLen <= '0;
				walkIdx <= '0;
				opAddr <= fullAddr;
				activeOp <= reqOp;
			end
			else if (busy)
			begin
				busyCnt <= busyCnt - CW'(1);
				busyLen <= busyLen + CW'(1);
				if (!walkIdx[FLASH_AW])
					walkIdx <= walkIdx + (FLASH_AW + 1)'(1);
				if (busyCnt == CW'(1))
					activeOp <= OP_IDLE;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			fuseLow <= FUSE_RST;
			fuseHigh <= FUSE_RST;
			fuseExt <= FUSE_RST;
			lockBits <= LOCK_RST;
		end
		else if (clkEn)
		begin
			if (startOp && reqOp == OP_FUSE)
			begin
				if (byteSel == SEL_LOW)
					fuseLow <= dataLo;
				else if (byteSel == SEL_HIGH)
					fuseHigh <= dataLo;
				else if (byteSel == SEL_EXT)
					fuseExt <= dataLo;
			end
			if (startOp && reqOp == OP_LOCK)
				lockBits <= lockNext;
			// Locks clear only once the array erase has finished
			if (eraseDone)
				lockBits <= LOCK_RST;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			flashValid <= '0;
			eepromValid <= '0;
		end
		else if (clkEn)
		begin
			if (cmdLoad && dataIn == CMD_NOP)
			begin
				flashValid <= '0;
				eepromValid <= '0;
			end
			// A latch in the same cycle as the clear survives
			if (drainFire && !latchOut.eeprom)
				flashValid[latchOut.index[FLASH_PAGE_AW-1:0]] <= 1'b1;
			if (drainFire && latchOut.eeprom)
				eepromValid[latchOut.index[EEPROM_PAGE_AW-1:0]] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	busyStart_a: assert property (@(posedge clk) disable iff (!resetn)
		startOp |=> !readyBusy)
		else $error("ready/busy not low after write pulse");
	busyIgnore_a: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && writeFall && busyCnt > CW'(1) |=> $stable(activeOp))
		else $error("write pulse accepted while busy");
	writeLength_a: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && busyCnt == CW'(1) && !isErase
		|-> busyLen == CW'(WRITE_CYCLES - 1))
		else $error("write busy length wrong");
	nopClear_a: assert property (@(posedge clk) disable iff (!resetn)
		cmdLoad && dataIn == CMD_NOP && !drainFire
		|=> flashValid == '0 && eepromValid == '0)
		else $error("no-operation did not clear write state");
	lockErase_a: assert property (@(posedge clk) disable iff (!resetn)
		(lockBits & ~$past(lockBits)) != 8'h00
		|-> $past(eraseDone))
		else $error("lock bit unprogrammed without erase");
	bootGuard_a: assert property (@(posedge clk) disable iff (!resetn)
		startOp && reqOp == OP_LOCK && lockBits[1:0] == 2'b00
		|=> lockBits[5:2] == $past(lockBits[5:2]))
		else $error("boot lock bits changed in lock mode 3");
	fuseHigh_a: assert property (@(posedge clk) disable iff (!resetn)
		startOp && reqOp == OP_FUSE && byteSel == SEL_HIGH
		|=> fuseHigh == $past(dataLo) && fuseLow == $past(fuseLow))
		else $error("high fuse not written");
	fuseExt_a: assert property (@(posedge clk) disable iff (!resetn)
		startOp && reqOp == OP_FUSE && byteSel == SEL_EXT
		|=> fuseExt == $past(dataLo))
		else $error("extended fuse not written");
	busRelease_a: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && outputEnableN |=> !dataOe)
		else $error("data bus not released");
	driveOnly_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(clkEn) && dataOe |-> $past(driveWant))
		else $error("data bus driven outside a read");
	flashRead_a: assert property (@(posedge clk) disable iff (!resetn)
		clkEn && cmd == CMD_RD_FLASH && byteSelectOne
		|=> dataOut == $past(flashRdWord[15:8]))
		else $error("flash high byte not presented");
	cmdHold_a: assert property (@(posedge clk) disable iff (!resetn)
		!cmdLoad |=> $stable(cmd))
		else $error("command changed without a load");
endmodule
`default_nettype wire

// ---- pkg/pnp_pkg.sv ----
package pnp_pkg;

	// ------------------------------------------------------------
	// Command bytes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
	localparam logic [7:0] CMD_RD_SIG = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

	// ------------------------------------------------------------
	// Selector encodings
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ACT_ADDR = 2'b00,
		ACT_DATA = 2'b01,
		ACT_CMD = 2'b10,
		ACT_IDLE = 2'b11
	} pnp_action_type;

	// Byte select pair, written {two, one}
	localparam logic [1:0] SEL_LOW = 2'b00;
	localparam logic [1:0] SEL_HIGH = 2'b01;
	localparam logic [1:0] SEL_EXT = 2'b10;
	localparam logic [1:0] SEL_TOP = 2'b11;

	typedef enum logic [2:0]
	{
		OP_IDLE = 3'b000,
		OP_FLASH = 3'b001,
		OP_EEPROM = 3'b010,
		OP_FUSE = 3'b011,
		OP_LOCK = 3'b100,
		OP_ERASE = 3'b101
	} pnp_op_type;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int WRITE_MIN_NS = 3700000;
	localparam int ERASE_MIN_NS = 7500000;
	localparam int WRITE_CYC = (WRITE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYC = (ERASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Reset values and masks
	// ------------------------------------------------------------
	localparam logic [7:0] FUSE_RST = 8'hff;
	localparam logic [7:0] LOCK_RST = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [7:0] LOCK_BOOT_MASK = 8'h3c;
	localparam logic [7:0] SIG_NONE = 8'h00;
	localparam logic [7:0] SIG_LAST = 8'h02;

	typedef struct packed
	{
		logic eeprom;
		logic [7:0] index;
		logic [15:0] word;
	} pnp_latch_type;

endpackage

// ---- verilog/pnp_skid_buffer.sv ----
`timescale 1ns/1ns
`default_nettype none
module pnp_skid_buffer
#(
	parameter int WIDTH = 25,
	parameter int DEPTH = 2
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [CW-1:0] count;
	wire push = clkEn && inValid && inReady;
	wire pop = clkEn && outValid && outReady;

	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : gDepthCheck
		$error("buffer depth must be a power of two, at least 2");
	end

	assign inReady = (count != CW'(DEPTH));
	assign outValid = (count != '0);
	assign outData = store[rdPtr];

	always_ff @(posedge clk)
	begin
		if (push)
			store[wrPtr] <= inData;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wrPtr <= wrPtr + AW'(1);
			if (pop)
				rdPtr <= rdPtr + AW'(1);
			if (push && !pop)
				count <= count + CW'(1);
			else if (pop && !push)
				count <= count - CW'(1);
		end
	end

	bufCount_a: assert property (@(posedge clk) disable iff (!resetn)
		push && !pop |=> count == $past(count) + CW'(1))
		else $error("buffer count did not rise on push");
endmodule
`default_nettype wire

// ---- sim/pnp_programmer_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pnp_programmer_model
	import pnp_pkg::*;
#(
	parameter int LIMIT = 5000
)
(
	input wire logic clk,
	input wire logic readyBusy,
	output logic loadStrobe,
	output logic actionSelectHi,
	output logic actionSelectLo,
	output logic byteSelectOne,
	output logic byteSelectTwo,
	output logic pageLatchStrobe,
	output logic writeN,
	output logic outputEnableN,
	output logic drive,
	output logic [7:0] driveData
);
	import pnp_pkg::*;

	initial
	begin
		loadStrobe = 1'b0;
		{actionSelectHi, actionSelectLo} = ACT_IDLE;
		{byteSelectTwo, byteSelectOne} = SEL_LOW;
		pageLatchStrobe = 1'b0;
		writeN = 1'b1;
		outputEnableN = 1'b1;
		drive = 1'b1;
		driveData = 8'h00;
	end

	// ------------------------------------------------------------
	// Pin sequences
	// ------------------------------------------------------------
	task automatic load(input pnp_action_type act, input logic [1:0] sel,
		input logic [7:0] d);
		@(negedge clk);
		{actionSelectHi, actionSelectLo} = act;
		{byteSelectTwo, byteSelectOne} = sel;
		driveData = d;
		loadStrobe = 1'b1;
		@(negedge clk);
		loadStrobe = 1'b0;
		{actionSelectHi, actionSelectLo} = ACT_IDLE;
	endtask

	task automatic latch();
		@(negedge clk);
		byteSelectOne = 1'b1;
		pageLatchStrobe = 1'b1;
		@(negedge clk);
		pageLatchStrobe = 1'b0;
		byteSelectOne = 1'b0;
	endtask

	// Stray pulse mid-busy mimics a careless programmer
	task automatic writeOp(input logic [1:0] sel, input bit stray,
		output int lowCnt);
		int i;
		lowCnt = 0;
		@(negedge clk);
		{byteSelectTwo, byteSelectOne} = sel;
		writeN = 1'b0;
		@(negedge clk);
		writeN = 1'b1;
		// Busy already stands at this edge, so it counts too
		if (readyBusy === 1'b0)
			lowCnt++;
		for (i = 0; i < LIMIT && (i < 2 || readyBusy === 1'b0); i++)
		begin
			@(negedge clk);
			if (readyBusy === 1'b0)
				lowCnt++;
			writeN = !(stray && i == 10);
		end
		{byteSelectTwo, byteSelectOne} = SEL_LOW;
	endtask

	task automatic readOn(input logic [1:0] sel);
		@(negedge clk);
		{byteSelectTwo, byteSelectOne} = sel;
		drive = 1'b0;
		outputEnableN = 1'b0;
		@(negedge clk);
		@(negedge clk);
	endtask

	task automatic readOff();
		outputEnableN = 1'b1;
		@(negedge clk);
		@(negedge clk);
		drive = 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- sim/pnp_parallel_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module pnp_parallel_port_tb;
	import pnp_pkg::*;
	localparam int WR_CYC = 100;
	localparam int ER_CYC = 2000;
	localparam int LIMIT = 5000;
	// Identity values are arbitrary
	localparam logic [7:0] SIG0 = 8'h5a;
	localparam logic [7:0] SIG1 = 8'h3c;
	localparam logic [7:0] SIG2 = 8'h0f;
	localparam logic [7:0] CALIB = 8'h80;
	logic clk, resetn, clkEn;
	logic loadStrobe, actionSelectHi, actionSelectLo, byteSelectOne;
	logic byteSelectTwo, pageLatchStrobe, writeN, outputEnableN, drive;
	logic [7:0] driveData, dataOut, busData;
	logic dataOe, readyBusy, pageLatchReady;
	int nErrors = 0;
	int checked = 0;
	int cnt, i;
	logic [7:0] fuseVal [3] = '{8'he2, 8'hd9, 8'hfd};
	logic [1:0] wrSel [3] = '{SEL_LOW, SEL_HIGH, SEL_EXT};
	logic [1:0] rdSel [3] = '{SEL_LOW, SEL_TOP, SEL_EXT};
	logic [7:0] sigVal [4] = '{SIG0, SIG1, SIG2, SIG_NONE};

	// Released bus shows the inverse, never a stale match
	assign busData = dataOe ? dataOut : (drive ? driveData : ~driveData);

	pnp_parallel_port #(.WRITE_CYCLES(WR_CYC), .ERASE_CYCLES(ER_CYC),
		.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
		.CALIB_BYTE(CALIB)) dut (.clk(clk), .resetn(resetn), .clkEn(clkEn),
		.loadStrobe(loadStrobe), .actionSelectHi(actionSelectHi),
		.actionSelectLo(actionSelectLo), .byteSelectOne(byteSelectOne),
		.byteSelectTwo(byteSelectTwo), .pageLatchStrobe(pageLatchStrobe),
		.writeN(writeN), .outputEnableN(outputEnableN), .dataIn(busData),
		.dataOut(dataOut), .dataOe(dataOe), .readyBusy(readyBusy),
		.pageLatchReady(pageLatchReady));

	pnp_programmer_model #(.LIMIT(LIMIT)) prog (.clk(clk),
		.readyBusy(readyBusy), .loadStrobe(loadStrobe),
		.actionSelectHi(actionSelectHi), .actionSelectLo(actionSelectLo),
		.byteSelectOne(byteSelectOne), .byteSelectTwo(byteSelectTwo),
		.pageLatchStrobe(pageLatchStrobe), .writeN(writeN),
		.outputEnableN(outputEnableN), .drive(drive),
		.driveData(driveData));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Checks and access helpers
	// ------------------------------------------------------------
	task automatic endSim();
		if (nErrors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			nErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
		prog.readOn(sel);
		chk({7'h00, dataOe, busData}, {8'h01, exp});
		prog.readOff();
		chk(16'(dataOe), 16'h0000);
	endtask

	task automatic wr(input logic [1:0] sel, input bit stray, input int exp);
		prog.writeOp(sel, stray, cnt);
		if (cnt >= LIMIT)
		begin
			nErrors++;
			endSim();
		end
		else
			chk(16'(cnt), 16'(exp));
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		clkEn = 1'b1;
		resetn = 1'b0;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		chk({13'h0, readyBusy, pageLatchReady, dataOe}, 16'h0006);
		prog.load(ACT_CMD, SEL_LOW, CMD_WR_FUSE);
		prog.readOn(SEL_LOW);
		chk(16'(dataOe), 16'h0000);
		prog.readOff();
		prog.load(ACT_CMD, SEL_LOW, CMD_ERASE);
		wr(SEL_LOW, 1'b0, ER_CYC);
		// Flash page write, then a cleared page that must not land
		prog.load(ACT_CMD, SEL_LOW, CMD_WR_FLASH);
		prog.load(ACT_ADDR, SEL_LOW, 8'h03);
		prog.load(ACT_DATA, SEL_LOW, 8'h12);
		prog.load(ACT_DATA, SEL_HIGH, 8'h34);
		prog.latch();
		wr(SEL_LOW, 1'b0, WR_CYC);
		prog.load(ACT_CMD, SEL_LOW, CMD_NOP);
		prog.load(ACT_CMD, SEL_LOW, CMD_WR_FLASH);
		prog.load(ACT_ADDR, SEL_LOW, 8'h05);
		prog.latch();
		prog.load(ACT_CMD, SEL_LOW, CMD_NOP);
		prog.load(ACT_CMD, SEL_LOW, CMD_WR_FLASH);
		wr(SEL_LOW, 1'b0, WR_CYC);
		prog.load(ACT_CMD, SEL_LOW, CMD_RD_FLASH);
		prog.load(ACT_ADDR, SEL_EXT, 8'h00);
		prog.load(ACT_ADDR, SEL_HIGH, 8'h00);
		rd(SEL_LOW, 8'hff);
		prog.load(ACT_ADDR, SEL_LOW, 8'h03);
		rd(SEL_LOW, 8'h12);
		rd(SEL_HIGH, 8'h34);
		// EEPROM page with a stray write pulse while busy
		prog.load(ACT_CMD, SEL_LOW, CMD_WR_EEPROM);
		prog.load(ACT_ADDR, SEL_HIGH, 8'h00);
		for (i = 0; i < 2; i++)
		begin
			prog.load(ACT_ADDR, SEL_LOW, 8'(i + 1));
			prog.load(ACT_DATA, SEL_LOW, 8'ha5 ^ 8'(i));
			prog.latch();
		end
		wr(SEL_LOW, 1'b1, WR_CYC);
		prog.load(ACT_CMD, SEL_LOW, CMD_RD_EEPROM);
		for (i = 0; i < 2; i++)
		begin
			prog.load(ACT_ADDR, SEL_LOW, 8'(i + 1));
			rd(SEL_LOW, 8'ha5 ^ 8'(i));
		end
		prog.load(ACT_CMD, SEL_LOW, CMD_WR_FUSE);
		for (i = 0; i < 3; i++)
		begin
			prog.load(ACT_DATA, SEL_LOW, fuseVal[i]);
			wr(wrSel[i], 1'b0, WR_CYC);
		end
		prog.load(ACT_CMD, SEL_LOW, CMD_RD_FUSE);
		prog.load(ACT_IDLE, SEL_LOW, 8'h00);
		for (i = 0; i < 3; i++)
			rd(rdSel[i], fuseVal[i]);
		prog.load(ACT_CMD, SEL_LOW, CMD_RD_SIG);
		for (i = 0; i < 4; i++)
		begin
			prog.load(ACT_ADDR, SEL_LOW, 8'(i));
			rd(SEL_LOW, sigVal[i]);
		end
		prog.load(ACT_ADDR, SEL_LOW, 8'h00);
		rd(SEL_HIGH, CALIB);
		// Lock mode 3, then a boot lock attempt while the buffer fills
		prog.load(ACT_CMD, SEL_LOW, CMD_WR_LOCK);
		prog.load(ACT_DATA, SEL_LOW, 8'hfc);
		wr(SEL_LOW, 1'b0, WR_CYC);
		prog.load(ACT_DATA, SEL_LOW, 8'hc3);
		fork
			wr(SEL_LOW, 1'b0, WR_CYC);
			begin
				repeat (5) @(negedge clk);
				prog.latch();
				prog.latch();
				chk(16'(pageLatchReady), 16'h0000);
			end
		join
		repeat (3) @(negedge clk);
		chk(16'(pageLatchReady), 16'h0001);
		prog.load(ACT_DATA, SEL_LOW, 8'hff);
		wr(SEL_LOW, 1'b0, WR_CYC);
		prog.load(ACT_CMD, SEL_LOW, CMD_RD_FUSE);
		rd(SEL_HIGH, 8'hfc);
		prog.load(ACT_CMD, SEL_LOW, CMD_ERASE);
		// Ten frozen edges stretch busy by ten cycles
		fork
			wr(SEL_LOW, 1'b0, ER_CYC + 10);
			begin
				repeat (20) @(negedge clk);
				clkEn = 1'b0;
				repeat (10) @(negedge clk);
				clkEn = 1'b1;
			end
		join
		prog.load(ACT_CMD, SEL_LOW, CMD_RD_FUSE);
		rd(SEL_HIGH, LOCK_RST);
		endSim();
	end
endmodule
`default_nettype wire
